// *** inc/rsc_pkg.sv ***
package rsc_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  // shortest brown-out dip that counts, a least time so rounded up
  localparam int BOD_MIN_NS = 2000;
  localparam int BOD_CYC_INT = (BOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BOD_CW = 6;
  localparam logic [BOD_CW-1:0] BOD_CYC = BOD_CW'(BOD_CYC_INT);

  // start-up delay choices, picked by the clock select fuses
  localparam int DLY_CW = 17;
  localparam logic [DLY_CW-1:0] DLY0_DEF = 17'h00010;
  localparam logic [DLY_CW-1:0] DLY1_DEF = 17'h00400;
  localparam logic [DLY_CW-1:0] DLY2_DEF = 17'h01000;
  localparam logic [DLY_CW-1:0] DLY3_DEF = 17'h10000;
  localparam int CLOCK_SELECT_FUSES_W = 4;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int AW = 8;
  localparam logic [AW-1:0] OFS_FLAGS = 8'h00;
  localparam logic [AW-1:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [AW-1:0] OFS_IRQ_MASK = 8'h08;

  localparam int FLAG_W = 4;
  localparam int FLAG_POR_BIT = 0;
  localparam int FLAG_PIN_BIT = 1;
  localparam int FLAG_BO_BIT = 2;
  localparam int FLAG_WD_BIT = 3;
  localparam logic [FLAG_W-1:0] FLAGS_POR_VAL = 4'h1;

  localparam int EVT_W = 2;
  localparam int EVT_START_BIT = 0;
  localparam int EVT_DIP_BIT = 1;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic {
    RSC_COUNT = 1'b0,
    RSC_RUN = 1'b1
  } rsc_dly_phase_type;

  typedef struct packed {
    rsc_dly_phase_type phase;
    logic [DLY_CW-1:0] cnt;
  } rsc_dly_state_type;

  typedef struct packed {
    logic [BOD_CW-1:0] lowCnt;
    logic recog;
    logic dip;
  } rsc_filt_state_type;

  typedef struct packed {
    logic [FLAG_W-1:0] flags;
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] mask;
    logic wdPulse;
    logic wdPrev;
    logic holdPrev;
    logic fetch;
    logic ready;
    logic err;
    logic [31:0] rdata;
  } rsc_top_state_type;

  localparam rsc_top_state_type TOP_RST = '{
    flags: FLAGS_POR_VAL,
    holdPrev: 1'b1,
    default: '0
  };

endpackage

// *** hdl/rsc_dip_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_dip_filter #(
  parameter logic [rsc_pkg::BOD_CW-1:0] MIN_CYC = rsc_pkg::BOD_CYC
) (
  input wire logic clk,          // device clock
  input wire logic reset_n,      // power-on reset
  input wire logic enable,       // brown-out enable fuse
  input wire logic below,        // comparator: supply under trigger
  output logic recognised,       // qualified brown-out
  output logic dipRejected       // pulse: dip too short to count
);

  rsc_pkg::rsc_filt_state_type st_r, st_nxt;
  logic [rsc_pkg::BOD_CW-1:0] runLen_r;

  // ---------------------------------------------------------------
  // dip qualification
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.dip = 1'b0;
    if (enable && below) begin
      if (st_r.lowCnt != MIN_CYC) begin
        st_nxt.lowCnt = st_r.lowCnt + 1'b1;
      end
      st_nxt.recog = (st_nxt.lowCnt == MIN_CYC);
    end else begin
      st_nxt.dip = (st_r.lowCnt != '0) && !st_r.recog;
      st_nxt.lowCnt = '0;
      st_nxt.recog = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign recognised = st_r.recog;
  assign dipRejected = st_r.dip;

  // independent run counter, read only by the checks below
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      runLen_r <= '0;
    end else if (!(enable && below)) begin
      runLen_r <= '0;
    end else if (runLen_r != '1) begin
      runLen_r <= runLen_r + 1'b1;
    end
  end

  a_bod_short_ignored: assert property (
    @(posedge clk) disable iff (!reset_n) recognised |-> runLen_r >= MIN_CYC)
    else $error("brown-out recognised before minimum dip time");

  a_bod_fuse_gate: assert property (
    @(posedge clk) disable iff (!reset_n) !(enable && below) |=> !recognised)
    else $error("brown-out held without enabled low supply");

endmodule // rsc_dip_filter

`default_nettype wire

// *** hdl/rsc_startup_delay.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_startup_delay (
  input wire logic clk,                            // device clock
  input wire logic srcClear_n,                     // low while any source active
  input wire logic [rsc_pkg::DLY_CW-1:0] limit,    // delay in cycles, at least 1
  output logic holdReset                           // internal reset
);

  rsc_pkg::rsc_dly_state_type st_r, st_nxt;

  // ---------------------------------------------------------------
  // delay counter
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.phase)
      rsc_pkg::RSC_COUNT: begin
        st_nxt.cnt = st_r.cnt + 1'b1;
        // >= so that a fuse change mid-count cannot stall the release
        if (st_r.cnt >= limit - 1'b1) begin
          st_nxt.phase = rsc_pkg::RSC_RUN;
        end
      end
      rsc_pkg::RSC_RUN: begin
        st_nxt.cnt = st_r.cnt;
      end
    endcase
  end

  always_ff @(posedge clk or negedge srcClear_n) begin
    if (!srcClear_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign holdReset = (st_r.phase != rsc_pkg::RSC_RUN);

  a_run_sticky: assert property (
    @(posedge clk) disable iff (!srcClear_n)
    (st_r.phase == rsc_pkg::RSC_RUN) |=> (st_r.phase == rsc_pkg::RSC_RUN))
    else $error("release dropped without a reset source");

endmodule // rsc_startup_delay

`default_nettype wire

// *** hdl/reset_source_controller.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - reset I/O registers, then fetch reset vector
// - ports reset asynchronously by any source
// - fuse-selected delay stretches internal reset
// - exactly four sources, watchdog/brown-out gated
// - long pin low resets without clock
// - pin release starts delay counter
// - power-on holds, releases through delay
// - brown-out asserts immediately, releases through delay
// - brown-out needs minimum dip time
// - watchdog pulse one cycle, delay after
// - watchdog flag, cleared by power-on/write zero
// - brown-out flag, cleared by power-on/write zero
// - pin flag, cleared by power-on/write zero
// - power-on flag cleared only by write zero
// - flag bits seven to four read zero
module reset_source_controller #(
  parameter logic [rsc_pkg::DLY_CW-1:0] DELAY0_CYC = rsc_pkg::DLY0_DEF,
  parameter logic [rsc_pkg::DLY_CW-1:0] DELAY1_CYC = rsc_pkg::DLY1_DEF,
  parameter logic [rsc_pkg::DLY_CW-1:0] DELAY2_CYC = rsc_pkg::DLY2_DEF,
  parameter logic [rsc_pkg::DLY_CW-1:0] DELAY3_CYC = rsc_pkg::DLY3_DEF
) (
  input wire logic clk,                                  // device clock, 25 MHz
  input wire logic reset_n,                              // power-on detector, low below level
  input wire logic pinReset_n,                           // external reset pin level
  input wire logic brownoutLow,                          // supply under brown-out trigger
  input wire logic brownoutEnableFuse,                   // brown-out detector enabled
  input wire logic [rsc_pkg::CLOCK_SELECT_FUSES_W-1:0] clockSelectFuses, // delay choice
  input wire logic watchdogEnable,                       // watchdog running
  input wire logic watchdogTimeout,                      // watchdog period expired
  input wire logic psel,                                 // APB select
  input wire logic penable,                              // APB enable
  input wire logic pwrite,                               // APB write
  input wire logic [rsc_pkg::AW-1:0] paddr,              // APB byte address
  input wire logic [31:0] pwdata,                        // APB write data
  output logic [31:0] prdata,                            // APB read data
  output logic pready,                                   // APB ready
  output logic pslverr,                                  // APB unmapped access
  output logic portReset,                                // async I/O port reset
  output logic internalReset,                            // stretched core reset
  output logic fetchVector,                              // pulse: start at reset vector
  output logic irq                                       // level interrupt
);

  rsc_pkg::rsc_top_state_type st_r, st_nxt;

  logic bodRecognised;
  logic dipRejected;
  logic srcActive;
  logic [rsc_pkg::DLY_CW-1:0] delayLimit;
  logic access;
  logic loadPhase;
  logic wrDone;
  logic hit;
  logic [31:0] rdMux;
  logic [rsc_pkg::FLAG_W-1:0] flagSet;
  logic [rsc_pkg::EVT_W-1:0] evtSet;
  logic [rsc_pkg::DLY_CW-1:0] quietCnt_r;

  // ---------------------------------------------------------------
  // reset sources
  // ---------------------------------------------------------------
  rsc_dip_filter u_dip_filter (
    .clk(clk),
    .reset_n(reset_n),
    .enable(brownoutEnableFuse),
    .below(brownoutLow),
    .recognised(bodRecognised),
    .dipRejected(dipRejected)
  );

  // pin acts unclocked
  // any source needs no clock to hit the ports; filtered sources are
  // flop outputs so the async path stays glitch free
  assign srcActive = !reset_n || !pinReset_n || bodRecognised || st_r.wdPulse;
  assign portReset = srcActive;

  // ---------------------------------------------------------------
  // start-up delay
  // ---------------------------------------------------------------
  function automatic logic [rsc_pkg::DLY_CW-1:0] pickDelay(
    input logic [rsc_pkg::CLOCK_SELECT_FUSES_W-1:0] sel
  );
    logic [rsc_pkg::DLY_CW-1:0] d;
    d = DELAY0_CYC;
    unique case (sel[1:0])
      2'h0: d = DELAY0_CYC;
      2'h1: d = DELAY1_CYC;
      2'h2: d = DELAY2_CYC;
      2'h3: d = DELAY3_CYC;
    endcase
    return d;
  endfunction

  assign delayLimit = pickDelay(clockSelectFuses);

  rsc_startup_delay u_startup_delay (
    .clk(clk),
    .srcClear_n(!srcActive),
    .limit(delayLimit),
    .holdReset(internalReset)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // one wait state: read data is registered in the first access cycle
  assign access = psel && penable;
  assign loadPhase = access && !st_r.ready;
  assign wrDone = access && st_r.ready && pwrite && !st_r.err;
  assign hit = (paddr == rsc_pkg::OFS_FLAGS) || (paddr == rsc_pkg::OFS_IRQ_STAT) ||
               (paddr == rsc_pkg::OFS_IRQ_MASK);

  always_comb begin
    rdMux = '0;
    unique case (paddr)
      rsc_pkg::OFS_FLAGS: rdMux[rsc_pkg::FLAG_W-1:0] = st_r.flags;
      rsc_pkg::OFS_IRQ_STAT: rdMux[rsc_pkg::EVT_W-1:0] = st_r.evt;
      rsc_pkg::OFS_IRQ_MASK: rdMux[rsc_pkg::EVT_W-1:0] = st_r.mask;
      default: rdMux = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    flagSet = '0;
    evtSet = '0;

    // one-cycle watchdog pulse
    // edge taken so a held timeout still yields one pulse
    st_nxt.wdPrev = watchdogTimeout;
    st_nxt.wdPulse = watchdogEnable && watchdogTimeout && !st_r.wdPrev;

    st_nxt.holdPrev = internalReset;
    st_nxt.fetch = st_r.holdPrev && !internalReset;

    flagSet[rsc_pkg::FLAG_WD_BIT] = st_r.wdPulse;
    flagSet[rsc_pkg::FLAG_BO_BIT] = bodRecognised;
    flagSet[rsc_pkg::FLAG_PIN_BIT] = !pinReset_n;

    // concurrent sources all flagged
    // a source present in the clearing cycle wins over the write
    if (wrDone && (paddr == rsc_pkg::OFS_FLAGS)) begin
      st_nxt.flags = (st_r.flags & pwdata[rsc_pkg::FLAG_W-1:0]) | flagSet;
    end else begin
      st_nxt.flags = st_r.flags | flagSet;
    end

    // interrupt events, write one to clear, set wins
    evtSet[rsc_pkg::EVT_START_BIT] = st_r.holdPrev && !internalReset;
    evtSet[rsc_pkg::EVT_DIP_BIT] = dipRejected;
    if (wrDone && (paddr == rsc_pkg::OFS_IRQ_STAT)) begin
      st_nxt.evt = (st_r.evt & ~pwdata[rsc_pkg::EVT_W-1:0]) | evtSet;
    end else begin
      st_nxt.evt = st_r.evt | evtSet;
    end
    if (wrDone && (paddr == rsc_pkg::OFS_IRQ_MASK)) begin
      st_nxt.mask = pwdata[rsc_pkg::EVT_W-1:0];
    end

    // bus answer
    st_nxt.ready = loadPhase;
    if (loadPhase) begin
      st_nxt.rdata = rdMux;
      st_nxt.err = !hit;
    end
  end

  // power-on sets flag
  // only power-on restarts this state; other resets keep the flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= rsc_pkg::TOP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.ready && st_r.err;
  assign fetchVector = st_r.fetch;
  assign irq = |(st_r.evt & st_r.mask);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // cycles since the last source went away, read only by the checks
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      quietCnt_r <= '0;
    end else if (srcActive) begin
      quietCnt_r <= '0;
    end else if (quietCnt_r != '1) begin
      quietCnt_r <= quietCnt_r + 1'b1;
    end
  end

  a_port_src_follow: assert property (
    @(posedge clk) disable iff (!reset_n)
    (!pinReset_n || bodRecognised || st_r.wdPulse) |-> (portReset && internalReset))
    else $error("active source without port and internal reset");

  a_release_after_delay: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(internalReset) |-> (quietCnt_r == delayLimit))
    else $error("internal reset released after wrong delay");

  a_fetch_on_release: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(internalReset) |=> fetchVector ##1 !fetchVector)
    else $error("vector fetch not a single pulse at release");

  a_wd_pulse_width: assert property (
    @(posedge clk) disable iff (!reset_n)
    $rose(st_r.wdPulse) |=> (!st_r.wdPulse && internalReset))
    else $error("watchdog pulse not one cycle or delay skipped");

  a_wd_flag_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.wdPulse |=> st_r.flags[rsc_pkg::FLAG_WD_BIT])
    else $error("watchdog flag not set");

  a_bo_flag_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    bodRecognised |=> st_r.flags[rsc_pkg::FLAG_BO_BIT])
    else $error("brown-out flag not set");

  a_pin_flag_set: assert property (
    @(posedge clk) disable iff (!reset_n)
    !pinReset_n |=> st_r.flags[rsc_pkg::FLAG_PIN_BIT])
    else $error("pin flag not set");

  a_por_flag_keep: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_r.flags[rsc_pkg::FLAG_POR_BIT] &&
     !(wrDone && (paddr == rsc_pkg::OFS_FLAGS) && !pwdata[rsc_pkg::FLAG_POR_BIT]))
    |=> st_r.flags[rsc_pkg::FLAG_POR_BIT])
    else $error("power-on flag lost without a zero write");

  a_flag_rsvd_zero: assert property (
    @(posedge clk) disable iff (!reset_n)
    (loadPhase && (paddr == rsc_pkg::OFS_FLAGS)) |=> (prdata[31:rsc_pkg::FLAG_W] == '0))
    else $error("reserved flag bits read nonzero");

  a_irq_level: assert property (
    @(posedge clk) disable iff (!reset_n)
    (st_r.evt[rsc_pkg::EVT_DIP_BIT] && st_r.mask[rsc_pkg::EVT_DIP_BIT]) |-> irq)
    else $error("unmasked event without interrupt");

  // ---------------------------------------------------------------
  // bus, watchdog, source, event and flag checks
  // ---------------------------------------------------------------
  a_ready_one_cycle: assert property (
    @(posedge clk) disable iff (!reset_n)
    pready |=> !pready)
    else $error("bus ready held longer than one cycle");

  a_err_unmapped: assert property (
    @(posedge clk) disable iff (!reset_n)
    (loadPhase && !hit) |=> pslverr)
    else $error("unmapped access without error response");

  a_wd_gated: assert property (
    @(posedge clk) disable iff (!reset_n)
    !watchdogEnable |=> !st_r.wdPulse)
    else $error("watchdog pulse while watchdog disabled");

  a_wd_edge_only: assert property (
    @(posedge clk) disable iff (!reset_n)
    st_r.wdPrev |=> !st_r.wdPulse)
    else $error("watchdog pulse from a held timeout");

  a_wd_delay_start: assert property (
    @(posedge clk) disable iff (!reset_n)
    $fell(st_r.wdPulse) |-> ((quietCnt_r == '0) && internalReset))
    else $error("delay not restarted at watchdog pulse end");

  a_src_holds_core: assert property (
    @(posedge clk) disable iff (!reset_n)
    srcActive |-> internalReset)
    else $error("core reset released while a source is active");

  a_dip_event: assert property (
    @(posedge clk) disable iff (!reset_n)
    dipRejected |=> st_r.evt[rsc_pkg::EVT_DIP_BIT])
    else $error("short dip not reported");

  a_start_event: assert property (
    @(posedge clk) disable iff (!reset_n)
    fetchVector |-> st_r.evt[rsc_pkg::EVT_START_BIT])
    else $error("release not reported with vector fetch");

  // zero writes clear a flag unless its source fires in the same cycle
  a_wd_flag_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wrDone && (paddr == rsc_pkg::OFS_FLAGS) &&
     !pwdata[rsc_pkg::FLAG_WD_BIT] && !st_r.wdPulse)
    |=> !st_r.flags[rsc_pkg::FLAG_WD_BIT])
    else $error("watchdog flag survived a zero write");

  a_bo_flag_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wrDone && (paddr == rsc_pkg::OFS_FLAGS) &&
     !pwdata[rsc_pkg::FLAG_BO_BIT] && !bodRecognised)
    |=> !st_r.flags[rsc_pkg::FLAG_BO_BIT])
    else $error("brown-out flag survived a zero write");

  a_pin_flag_clear: assert property (
    @(posedge clk) disable iff (!reset_n)
    (wrDone && (paddr == rsc_pkg::OFS_FLAGS) &&
     !pwdata[rsc_pkg::FLAG_PIN_BIT] && pinReset_n)
    |=> !st_r.flags[rsc_pkg::FLAG_PIN_BIT])
    else $error("pin flag survived a zero write");

endmodule // reset_source_controller

`default_nettype wire

// *** tb/rsc_supply_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_supply_model (
  input wire logic clk,         // device clock
  input wire logic supplyOff,   // supply under power-on level
  input wire logic pinHold,     // pin held low from outside
  input wire logic dipGo,       // start a supply dip
  input wire logic [7:0] dipLen, // dip length in cycles
  output logic reset_n,         // power-on detector output
  output logic pinReset_n,      // reset pin level
  output logic brownoutLow      // comparator output
);
  logic [7:0] dipCnt_r = 8'h00;

  assign reset_n = !supplyOff;
  // pin pulled up once let go
  assign pinReset_n = !pinHold;
  always @(posedge clk) begin
    if (dipGo) begin
      dipCnt_r <= dipLen;
    end else if (dipCnt_r != 8'h00) begin
      dipCnt_r <= dipCnt_r - 8'h01;
    end
  end
  assign brownoutLow = (dipCnt_r != 8'h00);
endmodule // rsc_supply_model

`default_nettype wire

// *** tb/reset_source_controller_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module reset_source_controller_tb;
  // spaced apart so a wrong fuse decode cannot hide in the window
  localparam logic [16:0] D0 = 17'h00004;
  localparam logic [16:0] D1 = 17'h00009;
  localparam logic [16:0] D2 = 17'h0000E;
  localparam logic [16:0] D3 = 17'h00013;
  localparam logic [7:0] FL = rsc_pkg::OFS_FLAGS;
  localparam logic [7:0] ST = rsc_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] MK = rsc_pkg::OFS_IRQ_MASK;
  logic clk, supplyOff, pinHold, dipGo, bodFuse, wdEn, wdTo;
  logic reset_n, pinReset_n, brownoutLow;
  logic [7:0] dipLen, paddr;
  logic [3:0] fuses;
  logic psel, penable, pwrite, pready, pslverr, portReset, internalReset, fetchVector, irq;
  logic [31:0] pwdata, prdata;
  logic [32:0] expQ[$];
  logic [32:0] expV;
  logic [16:0] lims[4] = '{D0, D1, D2, D3};
  int fails = 0;
  int checksDone = 0;
  int cyc = 0;

  reset_source_controller #(.DELAY0_CYC(D0), .DELAY1_CYC(D1), .DELAY2_CYC(D2),
      .DELAY3_CYC(D3)) uut (.clk(clk), .reset_n(reset_n), .pinReset_n(pinReset_n),
      .brownoutLow(brownoutLow), .brownoutEnableFuse(bodFuse), .clockSelectFuses(fuses),
      .watchdogEnable(wdEn), .watchdogTimeout(wdTo), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .portReset(portReset), .internalReset(internalReset),
      .fetchVector(fetchVector), .irq(irq));

  rsc_supply_model partner (.clk(clk), .supplyOff(supplyOff), .pinHold(pinHold),
      .dipGo(dipGo), .dipLen(dipLen), .reset_n(reset_n), .pinReset_n(pinReset_n),
      .brownoutLow(brownoutLow));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // checking
  // ---------------------------------------------------------------
  task automatic completeRun();
    $display("comparisons %0d, mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    checksDone = checksDone + 1;
    if (ok !== 1'b1) begin
      fails = fails + 1;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails = fails + 1;
      $display("[FAIL] %0t run hung", $time);
      completeRun();
    end
  end

  // read results come off the queue in issue order
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (expQ.size() == 0) begin
        fails = fails + 1;
        $display("[FAIL] %0t read with no note", $time);
      end else begin
        expV = expQ.pop_front();
        check({pslverr, prdata} === expV, "read data");
      end
    end
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // request stands until the edge that samples ready high
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(a, 1'b0, 32'h00000000);
  endtask

  task automatic waitRel(input logic [16:0] l, input string msg);
    int n;
    logic fv;
    n = 0;
    while (internalReset === 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    fv = (fetchVector === 1'b1);
    @(posedge clk);
    #1;
    fv = fv | (fetchVector === 1'b1);
    check(n >= l && n <= l + 17'h00003 && fv, msg);
  endtask

  task automatic wdFire();
    @(posedge clk);
    wdTo <= 1'b1;
    @(posedge clk);
    wdTo <= 1'b0;
  endtask

  task automatic dip(input logic [7:0] len);
    @(posedge clk);
    dipGo <= 1'b1;
    dipLen <= len;
    @(posedge clk);
    dipGo <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h78fbd15e));
    supplyOff = 1'b1;
    pinHold = 1'b0;
    dipGo = 1'b0;
    dipLen = 8'h00;
    bodFuse = 1'b0;
    wdEn = 1'b0;
    wdTo = 1'b0;
    fuses = 4'($urandom_range(3, 0));
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    @(posedge clk);
    check(portReset === 1'b1 && internalReset === 1'b1 && irq === 1'b0, "reset");
    for (int k = 0; k < 5; k++) begin
      if (k > 0) begin
        @(posedge clk);
        supplyOff <= 1'b1;
        fuses <= 4'(k - 1);
        @(posedge clk);
        #1;
        check(internalReset === 1'b1 && portReset === 1'b1, "por again");
      end
      @(posedge clk);
      supplyOff <= 1'b0;
      waitRel(lims[fuses[1:0]], "por delay");
      rd(FL, 33'h000000001);
    end
    apb(FL, 1'b1, $urandom & 32'hFFFFFFF0);
    rd(FL, 33'h000000000);
    apb(MK, 1'b1, 32'h00000003);
    rd(ST, 33'h000000001);
    check(irq === 1'b1, "irq on");
    apb(MK, 1'b1, 32'h00000002);
    #1;
    check(irq === 1'b0, "irq masked");
    apb(ST, 1'b1, 32'h00000001);
    apb(MK, 1'b1, 32'h00000003);
    rd(ST, 33'h000000000);
    wdFire();
    repeat (2) @(posedge clk);
    #1;
    check(portReset === 1'b0 && internalReset === 1'b0, "wd disabled");
    wdEn <= 1'b1;
    wdFire();
    #1;
    check(portReset === 1'b1, "wd pulse");
    @(posedge clk);
    #1;
    check(portReset === 1'b0 && internalReset === 1'b1, "wd one cycle");
    waitRel(D3, "wd delay");
    rd(FL, 33'h000000008);
    check(irq === 1'b1, "irq release");
    apb(ST, 1'b1, 32'h00000003);
    @(posedge clk);
    pinHold <= 1'b1;
    #1;
    check(portReset === 1'b1 && internalReset === 1'b1, "pin async");
    wdFire();
    repeat (3) @(posedge clk);
    pinHold <= 1'b0;
    waitRel(D3, "pin delay");
    rd(FL, 33'h00000000A);
    apb(FL, 1'b1, 32'h00000002);
    rd(FL, 33'h000000002);
    dip(8'd60);
    repeat (70) @(posedge clk);
    #1;
    check(internalReset === 1'b0, "bod fuse off");
    apb(ST, 1'b1, 32'h00000003);
    bodFuse <= 1'b1;
    dip(8'(30 + $urandom_range(15, 0)));
    repeat (60) @(posedge clk);
    #1;
    check(internalReset === 1'b0, "short dip");
    rd(ST, 33'h000000002);
    dip(8'd60);
    repeat (rsc_pkg::BOD_CYC_INT + 3) @(posedge clk);
    #1;
    check(internalReset === 1'b1 && portReset === 1'b1, "bod on");
    do begin
      @(posedge clk);
      #1;
    end while (brownoutLow === 1'b1);
    waitRel(D3, "bod delay");
    rd(FL, 33'h000000006);
    rd(8'h0C, 33'h100000000);
    @(posedge clk);
    supplyOff <= 1'b1;
    repeat (2) @(posedge clk);
    supplyOff <= 1'b0;
    waitRel(D3, "final por");
    rd(FL, 33'h000000001);
    rd(MK, 33'h000000000);
    completeRun();
  end
endmodule // reset_source_controller_tb

`default_nettype wire
